// ===== rtl/smw_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Host only reads peek-only window regions
// - Controller keeps full access to exposed memory
// - Two independent regions, each with own base
// - Host may write code through write region
// - Zero tag stores any written value
// - Writing current nonzero tag clears it
// - Other value to nonzero tag ignored
// - Tag at runtime offset 0Ch, reset zero
// - Runtime page at 000F_0000 and host BAR
// - Controller-only page at 000F_0100, no host path
`include "smw_cfg.svh"

module smw_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host I/O access to the runtime block
    input wire logic [15:0] host_bar,
    input wire logic host_valid,
    input wire logic host_write,
    input wire logic [15:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // Host window access
    input wire logic host_mem_valid,
    input wire logic host_mem_write,
    input wire logic host_mem_region,
    input wire logic [15:0] host_mem_offset,
    input wire logic [31:0] host_mem_wdata,
    output logic [31:0] host_mem_rdata,
    output logic host_mem_done,
    // Controller register access
    input wire logic ec_valid,
    input wire logic ec_write,
    input wire logic [31:0] ec_addr,
    input wire logic [3:0] ec_be,
    input wire logic [31:0] ec_wdata,
    output logic [31:0] ec_rdata,
    output logic ec_ack,
    // Event to the controller
    output logic h2c_event,
    // Internal memory master
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack
);

    // ======================================================================
    // Offsets kept as byte addresses; word index is bits 7:2
    // ======================================================================
    localparam logic [7:0] OFS_H2C = `SMW_OFS_H2C;
    localparam logic [7:0] OFS_BASE0 = `SMW_OFS_BASE0;
    localparam logic [7:0] OFS_RDLIM0 = `SMW_OFS_RDLIM0;
    localparam logic [7:0] OFS_BASE1 = `SMW_OFS_BASE1;
    localparam logic [7:0] OFS_RDLIM1 = `SMW_OFS_RDLIM1;
    localparam logic [7:0] OFS_EVSET = `SMW_OFS_EVSET;
    localparam logic [7:0] RT_H2C = `SMW_RT_H2C;
    localparam logic [7:0] RT_C2H = `SMW_RT_C2H;
    localparam logic [7:0] RT_OWNER = `SMW_RT_OWNER;

    // ======================================================================
    // State
    // ======================================================================
    // Every register of the block in one record
    typedef struct packed {
        logic [7:0] h2c; // Host-to-controller mailbox
        logic [7:0] c2h; // Controller-to-host mailbox
        logic [31:0] base0; // Region 0 base
        logic [31:0] lim0; // Region 0 write limit high, read limit low
        logic [31:0] base1; // Region 1 base
        logic [31:0] lim1; // Region 1 write limit high, read limit low
        logic [31:0] evt; // Host clear permit high, event set low
        logic [7:0] owner; // Ownership tag
        logic evt_pend; // Host mailbox event pending
        logic [31:0] ec_rdata; // Controller read data
        logic ec_ack; // Controller access answer
        logic [7:0] host_rdata; // Host read data
    } smw_regs_s;

    smw_regs_s s_r;
    smw_regs_s s_nxt;

    // Decode terms
    logic host_hit; // Host access inside the runtime I/O block
    logic [7:0] host_ofs; // Host byte offset within the block
    logic rt_hit; // Controller access to the runtime page
    logic eo_hit; // Controller access to the controller-only page
    logic [5:0] ec_word; // Controller word index within a page
    logic [31:0] ec_rd; // Controller read word before registering

    // ======================================================================
    // Helpers
    // ======================================================================
    // Byte-lane merge for controller writes
    function automatic logic [31:0] smw_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : smw_merge

    // Claim and release rule for the ownership tag
    function automatic logic [7:0] smw_tag(input logic [7:0] cur, input logic [7:0] wr);
        logic [7:0] res;
        res = cur;
        if (cur == 8'h00) begin
            res = wr;
        end else if (wr == cur) begin
            res = 8'h00;
        end
        // Any other value leaves the tag as it is
        return res;
    endfunction : smw_tag

    // ======================================================================
    // Address decode
    // ======================================================================
    // Host block is 16 bytes at the programmed base; the controller-only
    // page has no host path at all, so window setup is safe from the host
    always_comb begin
        host_hit = host_valid && host_addr[15:4] == host_bar[15:4];
        host_ofs = {4'h0, host_addr[3:0]};
        rt_hit = ec_valid && ec_addr[31:8] == `SMW_RT_PAGE;
        eo_hit = ec_valid && ec_addr[31:8] == `SMW_EC_PAGE;
        ec_word = ec_addr[7:2];
    end

    // ======================================================================
    // Controller read mux
    // ======================================================================
    // Unmapped words and unused byte lanes read as zero
    always_comb begin
        ec_rd = 32'h0000_0000;
        if (rt_hit) begin
            if (ec_word == RT_H2C[7:2]) begin
                ec_rd = {16'h0000, s_r.c2h, s_r.h2c};
            end else if (ec_word == RT_OWNER[7:2]) begin
                ec_rd = {24'h00_0000, s_r.owner};
            end
        end else if (eo_hit) begin
            case (ec_word)
                OFS_H2C[7:2]: ec_rd = {16'h0000, s_r.c2h, s_r.h2c};
                OFS_BASE0[7:2]: ec_rd = s_r.base0;
                OFS_RDLIM0[7:2]: ec_rd = s_r.lim0;
                OFS_BASE1[7:2]: ec_rd = s_r.base1;
                OFS_RDLIM1[7:2]: ec_rd = s_r.lim1;
                OFS_EVSET[7:2]: ec_rd = s_r.evt;
                default: ec_rd = 32'h0000_0000;
            endcase
        end
    end

    // ======================================================================
    // Next register state
    // ======================================================================
    // Controller writes are applied before host writes, so a host
    // mailbox write in the same cycle as the acknowledge keeps the event
    always_comb begin
        s_nxt = s_r;
        s_nxt.ec_ack = ec_valid;
        s_nxt.ec_rdata = ec_write ? 32'h0000_0000 : ec_rd;
        // Controller writes to the controller-only page
        if (eo_hit && ec_write) begin
            case (ec_word)
                OFS_H2C[7:2]: begin
                    if (ec_be[0]) begin
                        // Controller touches its mailbox byte: acknowledge
                        s_nxt.h2c = ec_wdata[7:0];
                        s_nxt.evt_pend = 1'b0;
                    end
                    if (ec_be[1]) begin
                        s_nxt.c2h = ec_wdata[15:8];
                    end
                end
                OFS_BASE0[7:2]: s_nxt.base0 = smw_merge(s_r.base0, ec_wdata, ec_be);
                OFS_RDLIM0[7:2]: s_nxt.lim0 = smw_merge(s_r.lim0, ec_wdata, ec_be);
                OFS_BASE1[7:2]: s_nxt.base1 = smw_merge(s_r.base1, ec_wdata, ec_be);
                OFS_RDLIM1[7:2]: s_nxt.lim1 = smw_merge(s_r.lim1, ec_wdata, ec_be);
                OFS_EVSET[7:2]: s_nxt.evt = smw_merge(s_r.evt, ec_wdata, ec_be);
                default: begin
                    // Unmapped word: write is dropped
                end
            endcase
        end
        // Controller writes to the runtime page: only the tag
        if (rt_hit && ec_write && ec_word == RT_OWNER[7:2] && ec_be[0]) begin
            s_nxt.owner = smw_tag(s_r.owner, ec_wdata[7:0]);
        end
        // Host reads of the runtime block
        if (host_hit && !host_write) begin
            case (host_ofs)
                RT_H2C: s_nxt.host_rdata = s_r.h2c;
                RT_C2H: s_nxt.host_rdata = s_r.c2h;
                RT_OWNER: s_nxt.host_rdata = s_r.owner;
                default: s_nxt.host_rdata = 8'h00;
            endcase
        end
        // Host writes; the controller mailbox byte is read-only here
        if (host_hit && host_write) begin
            if (host_ofs == RT_H2C) begin
                // Carries the host's requests, such as a region change
                s_nxt.h2c = host_wdata;
                s_nxt.evt_pend = 1'b1;
            end else if (host_ofs == RT_OWNER) begin
                // Applied on top of a same-cycle controller write
                s_nxt.owner = smw_tag(s_nxt.owner, host_wdata);
            end
        end
    end

    // Register update; system reset clears the whole record
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.owner <= `SMW_OWNER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // Window engine
    // ======================================================================
    smw_win_if win_cfg ();

    // Hand each region's setup to the engine
    for (genvar g = 0; g < 2; g++) begin : g_region
        assign win_cfg.base[g] = (g == 0) ? s_r.base0 : s_r.base1;
        assign win_cfg.rd_lim[g] = (g == 0) ? s_r.lim0[15:0] : s_r.lim1[15:0];
        assign win_cfg.wr_lim[g] = (g == 0) ? s_r.lim0[31:16] : s_r.lim1[31:16];
    end

    // The controller never goes through this engine, so its own access to
    // exposed memory is untouched by any limit
    smw_win u_win (
        .clk(clk),
        .reset(reset),
        .cfg(win_cfg.win),
        .host_mem_valid(host_mem_valid),
        .host_mem_write(host_mem_write),
        .host_mem_region(host_mem_region),
        .host_mem_offset(host_mem_offset),
        .host_mem_wdata(host_mem_wdata),
        .host_mem_rdata(host_mem_rdata),
        .host_mem_done(host_mem_done),
        .mem_req(mem_req),
        .mem_write(mem_write),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );

    // Outputs
    assign host_rdata = s_r.host_rdata;
    assign ec_rdata = s_r.ec_rdata;
    assign ec_ack = s_r.ec_ack;
    assign h2c_event = s_r.evt_pend;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Host write to the tag with no controller runtime-page write alongside
    logic host_tag_wr;
    assign host_tag_wr = host_hit && host_write && host_ofs == RT_OWNER
                         && !(rt_hit && ec_write);

    a_tag_claim: assert property (
        (host_tag_wr && s_r.owner == 8'h00) |=> s_r.owner == $past(host_wdata))
        else $error("free tag did not take the written value");
    a_tag_release: assert property (
        (host_tag_wr && s_r.owner != 8'h00 && host_wdata == s_r.owner)
        |=> s_r.owner == 8'h00)
        else $error("matching write did not release the tag");
    a_tag_ignore: assert property (
        (host_tag_wr && s_r.owner != 8'h00 && host_wdata != s_r.owner)
        |=> $stable(s_r.owner))
        else $error("foreign write changed a held tag");
    a_tag_reset: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> s_r.owner == 8'h00)
        else $error("tag not cleared by reset");
    a_host_tag_read: assert property (
        (host_hit && !host_write && host_ofs == RT_OWNER && !ec_valid)
        |=> host_rdata == $past(s_r.owner))
        else $error("host read of tag returned wrong value");
    a_no_host_path: assert property (
        (host_valid && !(ec_valid && ec_write)) |=> $stable(s_r.base0) && $stable(s_r.lim1))
        else $error("host access changed window setup");
    a_event_raise: assert property (
        (host_hit && host_write && host_ofs == RT_H2C) |=> h2c_event)
        else $error("host mailbox write raised no event");
    a_event_ack: assert property (
        (eo_hit && ec_write && ec_word == OFS_H2C[7:2] && ec_be[0]
         && !(host_hit && host_write && host_ofs == RT_H2C)) |=> !h2c_event)
        else $error("acknowledge did not clear the event");
    a_ec_answer: assert property (
        (eo_hit && !ec_write && ec_word == OFS_BASE1[7:2]) |=> ec_ack && ec_rdata == $past(s_r.base1))
        else $error("controller read of base 1 wrong");

    c_tag_claim_release: cover property (host_tag_wr && s_r.owner == 8'h00 ##[1:20]
                                         host_tag_wr && host_wdata == s_r.owner);
    c_mailbox_ack: cover property (h2c_event ##[1:20] !h2c_event);
    c_window_done: cover property (host_mem_done);

endmodule : smw_top

// ===== rtl/smw_cfg.svh
`ifndef SMW_CFG_SVH
`define SMW_CFG_SVH

// ==========================================================================
// Address pages (upper 24 bits of the controller address)
// ==========================================================================
// Runtime page, internal base 000F_0000
`define SMW_RT_PAGE 24'h00_0F00
// Controller-only page, internal base 000F_0100
`define SMW_EC_PAGE 24'h00_0F01

// ==========================================================================
// Controller-only byte offsets
// ==========================================================================
`define SMW_OFS_H2C 8'h00
`define SMW_OFS_C2H 8'h01
`define SMW_OFS_BASE0 8'h04
`define SMW_OFS_RDLIM0 8'h08
`define SMW_OFS_WRLIM0 8'h0A
`define SMW_OFS_BASE1 8'h0C
`define SMW_OFS_RDLIM1 8'h10
`define SMW_OFS_WRLIM1 8'h12
`define SMW_OFS_EVSET 8'h14
`define SMW_OFS_HCLR 8'h16

// ==========================================================================
// Runtime byte offsets (controller page and host I/O block alike)
// ==========================================================================
`define SMW_RT_H2C 8'h00
`define SMW_RT_C2H 8'h01
`define SMW_RT_OWNER 8'h0C

// ==========================================================================
// Reset values
// ==========================================================================
`define SMW_OWNER_RST 8'h00
`define SMW_REG_RST 32'h0000_0000

`endif

// ===== rtl/smw_pkg.sv
// ==========================================================================
// Types shared by the shared memory window design
// ==========================================================================
package smw_pkg;

    // Host window engine states, Gray coded along idle, issue, done
    typedef enum logic [1:0] {
        SMW_IDLE = 2'b00,
        SMW_ISSUE = 2'b01,
        SMW_DONE = 2'b11
    } smw_win_state_e;

    // Per-region limit pair
    typedef logic [1:0][15:0] smw_lim_t;

    // Per-region base pair
    typedef logic [1:0][31:0] smw_base_t;

endpackage : smw_pkg

// ===== rtl/smw_win_if.sv
`timescale 1ns/100ps
// ==========================================================================
// Window setup carried from the register file to the window engine
// ==========================================================================
interface smw_win_if;
    smw_pkg::smw_base_t base; // Region base addresses
    smw_pkg::smw_lim_t rd_lim; // Region read limits in bytes
    smw_pkg::smw_lim_t wr_lim; // Region write limits in bytes

    modport regs (output base, output rd_lim, output wr_lim);
    modport win (input base, input rd_lim, input wr_lim);
endinterface : smw_win_if

// ===== rtl/smw_win.sv
`timescale 1ns/100ps
// ==========================================================================
// Host window engine: limit check and internal memory access
// ==========================================================================
module smw_win (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Window setup
    smw_win_if.win cfg,
    // Host window request
    input wire logic host_mem_valid,
    input wire logic host_mem_write,
    input wire logic host_mem_region,
    input wire logic [15:0] host_mem_offset,
    input wire logic [31:0] host_mem_wdata,
    output logic [31:0] host_mem_rdata,
    output logic host_mem_done,
    // Internal memory master
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack
);

    // All engine state
    typedef struct packed {
        smw_pkg::smw_win_state_e state;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } smw_win_s;

    smw_win_s s_r;
    smw_win_s s_nxt;
    logic [15:0] lim_sel; // Limit that applies to the request
    logic in_lim; // Request falls under that limit

    // Pick the limit of the addressed region and direction
    always_comb begin
        lim_sel = host_mem_write ? cfg.wr_lim[host_mem_region] : cfg.rd_lim[host_mem_region];
        in_lim = host_mem_offset < lim_sel;
    end

    // Next state
    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            smw_pkg::SMW_IDLE: begin
                if (host_mem_valid) begin
                    // Zero write limit leaves a peek-only region
                    s_nxt.write = host_mem_write;
                    s_nxt.addr = cfg.base[host_mem_region] + {16'h0000, host_mem_offset};
                    s_nxt.wdata = host_mem_wdata;
                    s_nxt.rdata = 32'h0000_0000;
                    // Outside the limit: read gives zero, write dropped
                    s_nxt.state = in_lim ? smw_pkg::SMW_ISSUE : smw_pkg::SMW_DONE;
                end
            end
            smw_pkg::SMW_ISSUE: begin
                // Hold the request until memory answers
                if (mem_ack) begin
                    s_nxt.rdata = s_r.write ? 32'h0000_0000 : mem_rdata;
                    s_nxt.state = smw_pkg::SMW_DONE;
                end
            end
            smw_pkg::SMW_DONE: begin
                s_nxt.state = smw_pkg::SMW_IDLE;
            end
            default: begin
                s_nxt.state = smw_pkg::SMW_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign mem_req = s_r.state == smw_pkg::SMW_ISSUE;
    assign mem_write = s_r.write;
    assign mem_addr = s_r.addr;
    assign mem_wdata = s_r.wdata;
    assign host_mem_rdata = s_r.rdata;
    assign host_mem_done = s_r.state == smw_pkg::SMW_DONE;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_peek_no_write: assert property (
        (s_r.state == smw_pkg::SMW_IDLE && host_mem_valid && host_mem_write
         && cfg.wr_lim[host_mem_region] == 16'h0000) |=> !mem_req ##1 !mem_req)
        else $error("write reached memory through a peek-only region");
    a_region_base: assert property (
        (s_r.state == smw_pkg::SMW_IDLE && host_mem_valid && in_lim)
        |=> mem_req && mem_addr == $past(cfg.base[host_mem_region]) + {16'h0000, $past(host_mem_offset)})
        else $error("memory address not base plus offset");
    a_write_through: assert property (
        (s_r.state == smw_pkg::SMW_IDLE && host_mem_valid && host_mem_write && in_lim)
        |=> mem_req && mem_write && mem_wdata == $past(host_mem_wdata))
        else $error("host write below limit not passed to memory");
    a_past_limit: assert property (
        (s_r.state == smw_pkg::SMW_IDLE && host_mem_valid && !in_lim)
        |=> host_mem_done && host_mem_rdata == 32'h0000_0000 && !mem_req)
        else $error("access past limit not refused");

    c_window_read: cover property (mem_req && !mem_write && mem_ack);
    c_window_write: cover property (mem_req && mem_write && mem_ack);

endmodule : smw_win

// ===== verification/smw_mem_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Internal memory seen by the window engine
// ==========================================================================
module smw_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Memory port
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack,
    // Traffic seen, for the bench
    output int n_req,
    output logic [31:0] last_addr,
    output logic [31:0] last_wdata
);
    int cnt; // Wait so far; latency cycles 0..2 so both fast and slow answers occur
    // Answer each request once; read data is the address with a fixed mask
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= {mem_rdata[30:0], ~mem_rdata[31]}; // Released bus keeps moving
        if (reset) begin
            cnt <= 0;
            n_req <= 0;
            mem_rdata <= 32'h0F0F_1234;
        end else if (mem_req && !mem_ack) begin
            cnt <= cnt + 1;
            if (cnt >= n_req % 3) begin
                mem_ack <= 1'b1;
                mem_rdata <= mem_addr ^ 32'hA5A5_0000;
                cnt <= 0;
                n_req <= n_req + 1;
                last_addr <= mem_addr;
                last_wdata <= mem_write ? mem_wdata : 32'h0000_0000;
            end
        end
    end
endmodule : smw_mem_model

// ===== verification/testbench.sv
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench: host I/O, controller bus and window traffic
// ==========================================================================
module testbench;
    // Design inputs, given values at time zero
    logic clk = 1'b0, reset = 1'b1, host_valid = 1'b0, host_write = 1'b0;
    logic host_mem_valid = 1'b0, host_mem_write = 1'b0, host_mem_region = 1'b0;
    logic ec_valid = 1'b0, ec_write = 1'b0;
    logic [15:0] host_bar = 16'h0A00, host_addr = 16'h0000, host_mem_offset = 16'h0000;
    logic [7:0] host_wdata = 8'h00;
    logic [31:0] host_mem_wdata = 32'h0000_0000, ec_addr = 32'h0000_0000;
    logic [31:0] ec_wdata = 32'h0000_0000;
    logic [3:0] ec_be = 4'h0;
    // Design and model outputs
    logic [7:0] host_rdata;
    logic [31:0] host_mem_rdata, ec_rdata, mem_addr, mem_wdata, mem_rdata, last_addr, last_wdata;
    logic host_mem_done, ec_ack, h2c_event, mem_req, mem_write, mem_ack;
    int n_req, n_mismatch = 0, check_count = 0, k, n0;
    initial begin
        forever #4 clk = ~clk;
    end
    smw_top smw_top_inst (.clk, .reset, .host_bar, .host_valid, .host_write, .host_addr,
        .host_wdata, .host_rdata, .host_mem_valid, .host_mem_write, .host_mem_region,
        .host_mem_offset, .host_mem_wdata, .host_mem_rdata, .host_mem_done, .ec_valid,
        .ec_write, .ec_addr, .ec_be, .ec_wdata, .ec_rdata, .ec_ack, .h2c_event, .mem_req,
        .mem_write, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    smw_mem_model smw_mem_model_inst (.clk, .reset, .mem_req, .mem_write, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack, .n_req, .last_addr, .last_wdata);
    // Counts, verdict and end of run
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // One comparison; four-state so unknowns never match
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Host I/O byte access at the programmed base; read byte lands one edge later
    task automatic hio(input logic wr, input logic [3:0] ofs, input logic [7:0] d);
        host_valid = 1'b1;
        host_write = wr;
        host_addr = {host_bar[15:4], ofs};
        host_wdata = d;
        @(negedge clk);
        host_valid = 1'b0;
        @(negedge clk);
    endtask : hio
    // Controller word access, all lanes enabled, bounded wait for the acknowledge
    task automatic eca(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(negedge clk);
        ec_valid = 1'b1;
        ec_write = wr;
        ec_addr = a;
        ec_wdata = d;
        ec_be = 4'hF;
        @(negedge clk);
        ec_valid = 1'b0;
        for (k = 0; k < 4 && ec_ack !== 1'b1; k++) @(negedge clk);
        if (k == 4) begin
            chk("ec_ack", 1'b1, ec_ack);
            give_verdict();
        end
    endtask : eca
    // Window access; checks read data and how many memory cycles it caused
    task automatic win(input logic wr, rg, input logic [15:0] ofs, input logic [31:0] exp,
                       input int nexp);
        n0 = n_req;
        host_mem_valid = 1'b1;
        host_mem_write = wr;
        host_mem_region = rg;
        host_mem_offset = ofs;
        host_mem_wdata = {16'hC0DE, ofs};
        @(negedge clk);
        host_mem_valid = 1'b0;
        for (k = 0; k < 20 && host_mem_done !== 1'b1; k++) @(negedge clk);
        if (k == 20) begin
            chk("host_mem_done", 1'b1, host_mem_done);
            give_verdict();
        end
        if (!wr) chk("window rdata", exp, host_mem_rdata);
        @(negedge clk);
        chk("memory cycles", n0 + nexp, n_req);
    endtask : win
    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        hio(1'b0, 4'hC, 8'h00);
        chk("tag after reset", 8'h00, host_rdata);
        hio(1'b1, 4'hC, 8'h5A);
        hio(1'b0, 4'hC, 8'h00);
        chk("tag claimed", 8'h5A, host_rdata);
        hio(1'b1, 4'hC, 8'h33);
        hio(1'b0, 4'hC, 8'h00);
        chk("tag kept", 8'h5A, host_rdata);
        eca(1'b0, 32'h000F_000C, 32'h0000_0000);
        chk("tag on runtime page", 32'h0000_005A, ec_rdata);
        hio(1'b1, 4'hC, 8'h5A);
        hio(1'b0, 4'hC, 8'h00);
        chk("tag released", 8'h00, host_rdata);
        eca(1'b1, 32'h000F_000C, 32'h0000_0042);
        hio(1'b0, 4'hC, 8'h00);
        chk("tag by controller", 8'h42, host_rdata);
        hio(1'b1, 4'h0, 8'h3C);
        chk("mailbox event", 1'b1, h2c_event);
        eca(1'b0, 32'h000F_0100, 32'h0000_0000);
        chk("mailbox word", 32'h0000_003C, ec_rdata);
        eca(1'b1, 32'h000F_0100, 32'h0000_7700);
        chk("mailbox event ack", 1'b0, h2c_event);
        hio(1'b0, 4'h1, 8'h00);
        chk("reply mailbox", 8'h77, host_rdata);
        eca(1'b1, 32'h000F_0104, 32'h2000_0000);
        eca(1'b1, 32'h000F_0108, 32'h0000_0010);
        eca(1'b1, 32'h000F_010C, 32'h3000_8000);
        eca(1'b1, 32'h000F_0110, 32'h0020_0008);
        eca(1'b0, 32'h000F_010C, 32'h0000_0000);
        chk("base1", 32'h3000_8000, ec_rdata);
        eca(1'b0, 32'h000F_0200, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, ec_rdata);
        win(1'b0, 1'b0, 16'h0004, 32'h85A5_0004, 1);
        chk("region0 addr", 32'h2000_0004, last_addr);
        win(1'b0, 1'b1, 16'h0004, 32'h95A5_8004, 1);
        win(1'b0, 1'b0, 16'h0010, 32'h0000_0000, 0);
        win(1'b1, 1'b0, 16'h0000, 32'h0000_0000, 0);
        win(1'b1, 1'b1, 16'h001C, 32'h0000_0000, 1);
        chk("code write", 32'hC0DE_001C, last_wdata);
        chk("code addr", 32'h3000_801C, last_addr);
        win(1'b1, 1'b1, 16'h0020, 32'h0000_0000, 0);
        give_verdict();
    end
endmodule : testbench
